// File: verilog/tsf_pkg.sv
// Constants, carrier types and the state record of the telemetry stream formatter.
package tsf_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses of 32-bit words).
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_CHAN0   = 8'h00;  // Channel zero source select.
  localparam logic [7:0] OFF_CHAN1   = 8'h04;  // Channel one source select.
  localparam logic [7:0] OFF_CHAN2   = 8'h08;  // Channel two source select.
  localparam logic [7:0] OFF_CHAN3   = 8'h0C;  // Channel three source select.
  localparam logic [7:0] OFF_PERIOD  = 8'h10;  // Streaming period readback, milliseconds.
  localparam logic [7:0] OFF_MODE    = 8'h14;  // Streaming mode setting.
  localparam logic [7:0] OFF_STATUS  = 8'h18;  // Busy flag and record counter.

  // ---------------------------------------------------------------------------
  // Field layouts and reset values.
  // ---------------------------------------------------------------------------
  localparam int         SEL_W       = 4;      // Width of a source select field.
  localparam int         NUM_SRC     = 11;     // Number of selectable quantities.
  localparam int         NUM_CHAN    = 4;      // Channels per record.
  localparam logic [3:0] SEL_RESET   = 4'h0;   // Channels come up disabled.
  localparam logic [1:0] MODE_OFF    = 2'h0;   // No records.
  localparam logic [1:0] MODE_ALWAYS = 2'h1;   // Records every period.
  localparam logic [1:0] MODE_MOVING = 2'h2;   // Records only while the motor runs.
  localparam int         STAT_BUSY   = 0;      // Status bit: a record is being sent.
  localparam int         STAT_MOVING = 1;      // Status bit: motor running input.
  localparam int         STAT_CNT_LO = 8;      // Status field: low bit of record count.

  // ---------------------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------------------
  localparam int PERIOD_MS     = 100;                          // Fixed record period.
  localparam int CLK_KHZ       = 200000;                       // Clock rate, 200 MHz.
  localparam int PERIOD_CYCLES = PERIOD_MS * CLK_KHZ;          // Cycles per period.
  localparam int TIMER_W       = 25;                           // Holds PERIOD_CYCLES.

  // ---------------------------------------------------------------------------
  // Characters of a record.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ASC_ZERO  = 8'h30;
  localparam logic [7:0] ASC_ONE   = 8'h31;
  localparam logic [7:0] ASC_COMMA = 8'h2C;
  localparam logic [7:0] ASC_MINUS = 8'h2D;
  localparam logic [7:0] ASC_CR    = 8'h0D;
  localparam logic [7:0] ASC_LF    = 8'h0A;
  localparam logic [3:0] TOP_DIGIT = 4'h9;     // Index of 10^9, the largest power used.

  // ---------------------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------------------
  // Formatter states, Gray coded in declaration order.
  typedef enum logic [2:0] {
    TSF_IDLE  = 3'h0,
    TSF_HDR0  = 3'h1,
    TSF_HDR1  = 3'h3,
    TSF_COMMA = 3'h2,
    TSF_SIGN  = 3'h6,
    TSF_DIGIT = 3'h7,
    TSF_CR    = 3'h5,
    TSF_LF    = 3'h4
  } tsf_state_e;

  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tsf_apb_req_s;

  // APB answer to the master.
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tsf_apb_rsp_s;

  // The eleven live quantities, index 0 is source code 1.
  typedef struct packed {
    logic [NUM_SRC-1:0][31:0] val;
  } tsf_quant_s;

  // Whole state of the formatter.
  typedef struct packed {
    logic [NUM_CHAN-1:0][SEL_W-1:0] sel;
    logic [1:0]                     mode;
    logic [TIMER_W-1:0]             timer;
    tsf_state_e                     state;
    logic [1:0]                     chan;
    logic [3:0]                     pidx;
    logic [3:0]                     dig;
    logic                           started;
    logic [31:0]                    mag;
    logic [NUM_CHAN-1:0][31:0]      snap;
    logic                           tx_valid;
    logic [7:0]                     tx_data;
    logic [31:0]                    rd_data;
    logic                           rd_err;
    logic [7:0]                     rec_cnt;
  } tsf_regs_s;

  // Power of ten for a digit position.
  function automatic logic [31:0] tsf_pow10(input logic [3:0] idx);
    case (idx)
      4'h0:    tsf_pow10 = 32'h0000_0001;
      4'h1:    tsf_pow10 = 32'h0000_000A;
      4'h2:    tsf_pow10 = 32'h0000_0064;
      4'h3:    tsf_pow10 = 32'h0000_03E8;
      4'h4:    tsf_pow10 = 32'h0000_2710;
      4'h5:    tsf_pow10 = 32'h0001_86A0;
      4'h6:    tsf_pow10 = 32'h000F_4240;
      4'h7:    tsf_pow10 = 32'h0098_9680;
      4'h8:    tsf_pow10 = 32'h05F5_E100;
      default: tsf_pow10 = 32'h3B9A_CA00;
    endcase
  endfunction

endpackage

// File: verilog/tsf_formatter.sv
// Telemetry stream formatter: APB registers, period timer and ASCII record builder.
`timescale 1ns/10ps

module tsf_formatter
  import tsf_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = PERIOD_CYCLES  // Cycles per record period.
) (
  input  wire logic         ref_clk,        // System clock, 200 MHz.
  input  wire logic         rst_n,          // Asynchronous reset, active low.
  input  wire tsf_apb_req_s apb_req,        // APB request.
  output tsf_apb_rsp_s      apb_rsp,        // APB answer.
  input  wire tsf_quant_s   quant,          // Live quantities, same clock domain.
  input  wire logic         motor_running,  // High while the motor moves, same clock domain.
  output logic              tx_valid,       // Record byte is valid.
  input  wire logic         tx_ready,       // Serial link takes the byte.
  output logic [7:0]        tx_data         // Record byte.
);

  // ---------------------------------------------------------------------------
  // State registers.
  // ---------------------------------------------------------------------------
  tsf_regs_s r;       // Present state.
  tsf_regs_s next_r;  // Next state.

  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(PERIOD_CYC - 1);  // Last timer count.

  // Reset value of the whole state.
  localparam tsf_regs_s REGS_RESET = '{
    sel:      {NUM_CHAN{SEL_RESET}},
    mode:     MODE_OFF,
    timer:    '0,
    state:    TSF_IDLE,
    chan:     2'h0,
    pidx:     4'h0,
    dig:      4'h0,
    started:  1'b0,
    mag:      32'h0000_0000,
    snap:     '0,
    tx_valid: 1'b0,
    tx_data:  8'h00,
    rd_data:  32'h0000_0000,
    rd_err:   1'b0,
    rec_cnt:  8'h00
  };

  // ---------------------------------------------------------------------------
  // Source selection.
  // ---------------------------------------------------------------------------
  logic [NUM_CHAN-1:0][31:0] picked;  // Live value chosen by each channel.

  // Each channel picks its own quantity; code 0 or an unused code gives zero.
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHAN; gc++) begin : g_pick
      always_comb begin
        if (r.sel[gc] != 4'h0 && r.sel[gc] <= 4'(NUM_SRC)) begin
          picked[gc] = quant.val[r.sel[gc] - 4'h1];
        end else begin
          picked[gc] = 32'h0000_0000;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------
  logic        setup;     // APB setup cycle.
  logic        wr_take;   // APB write takes effect this edge.
  logic        tick;      // One-cycle pulse at the end of each period.
  logic        fire;      // A record starts at this tick.
  logic        hold;      // Current byte still waits for the link.
  logic [31:0] cur_val;   // Snapshot of the channel being printed.
  logic [31:0] pow;       // Power of ten for the digit in work.

  assign setup   = apb_req.psel & ~apb_req.penable;
  assign wr_take = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign tick    = (r.timer == TIMER_LAST);
  assign hold    = r.tx_valid & ~tx_ready;
  assign cur_val = r.snap[r.chan];
  assign pow     = tsf_pow10(r.pidx);

  // Records start only on a period tick and only in a streaming mode.
  always_comb begin
    fire = 1'b0;
    if (tick) begin
      case (r.mode)
        MODE_ALWAYS: fire = 1'b1;
        MODE_MOVING: fire = motor_running;
        default:     fire = 1'b0;
      endcase
    end
  end

  // Registers, timer and the byte-by-byte record builder.
  always_comb begin
    next_r = r;

    // Free-running period counter; writes cannot change its length.
    if (tick) begin
      next_r.timer = '0;
    end else begin
      next_r.timer = r.timer + TIMER_W'(1);
    end

    // Register writes take effect at the access edge.
    if (wr_take) begin
      case (apb_req.paddr)
        OFF_CHAN0: next_r.sel[0] = apb_req.pwdata[SEL_W-1:0];
        OFF_CHAN1: next_r.sel[1] = apb_req.pwdata[SEL_W-1:0];
        OFF_CHAN2: next_r.sel[2] = apb_req.pwdata[SEL_W-1:0];
        OFF_CHAN3: next_r.sel[3] = apb_req.pwdata[SEL_W-1:0];
        OFF_MODE:  next_r.mode   = apb_req.pwdata[1:0];
        default: begin
          // The period readback and the status ignore writes.
        end
      endcase
    end

    // Read data and error are prepared in the setup cycle.
    if (setup) begin
      next_r.rd_data = 32'h0000_0000;
      next_r.rd_err  = 1'b0;
      case (apb_req.paddr)
        OFF_CHAN0:  next_r.rd_data[SEL_W-1:0] = r.sel[0];
        OFF_CHAN1:  next_r.rd_data[SEL_W-1:0] = r.sel[1];
        OFF_CHAN2:  next_r.rd_data[SEL_W-1:0] = r.sel[2];
        OFF_CHAN3:  next_r.rd_data[SEL_W-1:0] = r.sel[3];
        OFF_PERIOD: next_r.rd_data = 32'(PERIOD_MS);
        OFF_MODE:   next_r.rd_data[1:0] = r.mode;
        OFF_STATUS: begin
          next_r.rd_data[STAT_BUSY]               = (r.state != TSF_IDLE);
          next_r.rd_data[STAT_MOVING]             = motor_running;
          next_r.rd_data[STAT_CNT_LO+7:STAT_CNT_LO] = r.rec_cnt;
        end
        default:    next_r.rd_err = 1'b1;
      endcase
    end

    // Byte accepted by the link: drop valid unless a new byte replaces it.
    if (r.tx_valid && tx_ready) begin
      next_r.tx_valid = 1'b0;
    end

    // Builder advances only when the output byte is free.
    if (!hold) begin
      case (r.state)
        TSF_IDLE: begin
          // A tick during a record is skipped, so records never overlap.
          if (fire) begin
            next_r.snap     = picked;
            next_r.chan     = 2'h0;
            next_r.tx_valid = 1'b1;
            next_r.tx_data  = ASC_ZERO;
            next_r.state    = TSF_HDR0;
          end
        end
        TSF_HDR0: begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data  = ASC_ONE;
          next_r.state    = TSF_HDR1;
        end
        TSF_HDR1, TSF_COMMA: begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data  = ASC_COMMA;
          next_r.state    = TSF_SIGN;
        end
        TSF_SIGN: begin
          // Load the magnitude and print a minus for a negative value.
          next_r.pidx    = TOP_DIGIT;
          next_r.dig     = 4'h0;
          next_r.started = 1'b0;
          next_r.state   = TSF_DIGIT;
          if (cur_val[31]) begin
            next_r.mag      = 32'h0000_0000 - cur_val;
            next_r.tx_valid = 1'b1;
            next_r.tx_data  = ASC_MINUS;
          end else begin
            next_r.mag = cur_val;
          end
        end
        TSF_DIGIT: begin
          // Count a digit by repeated subtraction, then print it.
          if (r.mag >= pow) begin
            next_r.mag = r.mag - pow;
            next_r.dig = r.dig + 4'h1;
          end else begin
            next_r.dig = 4'h0;
            // Leading zeros are suppressed; the units digit always prints.
            if (r.started || r.dig != 4'h0 || r.pidx == 4'h0) begin
              next_r.started  = 1'b1;
              next_r.tx_valid = 1'b1;
              next_r.tx_data  = ASC_ZERO + {4'h0, r.dig};
            end
            if (r.pidx != 4'h0) begin
              next_r.pidx = r.pidx - 4'h1;
            end else if (r.chan == 2'(NUM_CHAN - 1)) begin
              next_r.state = TSF_CR;
            end else begin
              next_r.chan  = r.chan + 2'h1;
              next_r.state = TSF_COMMA;
            end
          end
        end
        TSF_CR: begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data  = ASC_CR;
          next_r.state    = TSF_LF;
        end
        TSF_LF: begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data  = ASC_LF;
          next_r.rec_cnt  = r.rec_cnt + 8'h01;
          next_r.state    = TSF_IDLE;
        end
        default: begin
          next_r.state = TSF_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register; reset brings the mode back to disabled.
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  assign tx_valid        = r.tx_valid;
  assign tx_data         = r.tx_data;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = r.rd_err & apb_req.psel & apb_req.penable;
  assign apb_rsp.prdata  = r.rd_data;

endmodule

// File: tb/tsf_formatter_sva.sv
// Concurrent checks on the ports of the telemetry stream formatter.
`timescale 1ns/10ps
module tsf_formatter_sva
  import tsf_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = PERIOD_CYCLES  // Cycles per record period.
) (
  input wire logic         ref_clk,        // System clock.
  input wire logic         rst_n,          // Reset, active low.
  input wire tsf_apb_req_s apb_req,        // APB request.
  input wire tsf_apb_rsp_s apb_rsp,        // APB answer.
  input wire tsf_quant_s   quant,          // Live quantities.
  input wire logic         motor_running,  // Motor moving.
  input wire logic         tx_valid,       // Record byte valid.
  input wire logic         tx_ready,       // Link takes the byte.
  input wire logic [7:0]   tx_data         // Record byte.
);
  // ---------------------------------------------------------------------------
  // Helper logic.
  // ---------------------------------------------------------------------------
  logic       at_start;  // The next byte offered opens a record.
  logic [1:0] mode_q;    // Streaming mode as last written over the bus.
  logic       acc;       // Bus access phase.
  assign acc = apb_req.psel && apb_req.penable;
  // Tracks record boundaries by the line feed, and mirrors the mode register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      at_start <= 1'b1;
      mode_q   <= MODE_OFF;
    end else begin
      if (tx_valid && tx_ready) begin
        at_start <= (tx_data == ASC_LF);
      end
      if (acc && apb_req.pwrite && apb_req.paddr == OFF_MODE) begin
        mode_q <= apb_req.pwdata[1:0];
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte changed while stalled");
  chk_start_zero: assert property (tx_valid && at_start |-> tx_data == ASC_ZERO)
    else $error("record does not open with zero");
  chk_header_one: assert property (tx_valid && tx_ready && at_start |=> tx_valid && tx_data == ASC_ONE)
    else $error("header second byte wrong");
  chk_period_read: assert property (acc && !apb_req.pwrite && apb_req.paddr == OFF_PERIOD |-> apb_rsp.prdata == 32'(PERIOD_MS))
    else $error("period readback wrong");
  chk_mode_read: assert property (acc && !apb_req.pwrite && apb_req.paddr == OFF_MODE |-> apb_rsp.prdata[1:0] == mode_q)
    else $error("mode readback wrong");
  chk_mode_gate: assert property ($rose(tx_valid) && at_start |-> $past(mode_q) == MODE_ALWAYS || $past(mode_q) == MODE_MOVING)
    else $error("record started while streaming is off");
  chk_moving_gate: assert property ($rose(tx_valid) && at_start && $past(mode_q) == MODE_MOVING |-> $past(motor_running))
    else $error("record started with motor stationary");
  chk_cr_lf: assert property (tx_valid && tx_ready && tx_data == ASC_CR |=> tx_valid && tx_data == ASC_LF)
    else $error("carriage return not followed by line feed");
endmodule

bind tsf_formatter tsf_formatter_sva #(.PERIOD_CYC(PERIOD_CYC)) u_sva (.ref_clk(ref_clk), .rst_n(rst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .quant(quant), .motor_running(motor_running), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data));

// File: tb/tsf_host_model.sv
// Serial link receiver standing in for the host: takes record bytes, stalling on request.
`timescale 1ns/10ps
module tsf_host_model (
  input  wire logic       ref_clk,   // System clock.
  input  wire logic       rst_n,     // Reset, active low.
  input  wire logic       tx_valid,  // Byte offered.
  input  wire logic [7:0] tx_data,   // Byte value.
  input  wire logic       stall,     // When high, accept only one cycle in four.
  output logic            tx_ready   // Byte taken at the edge where both are high.
);
  logic [7:0] rx_q[$];  // Bytes received, in order.
  logic [1:0] phase;    // Stall pattern counter.
  // Collects handed-over bytes and paces the ready line.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      phase    <= 2'h0;
    end else begin
      if (tx_valid && tx_ready) begin
        rx_q.push_back(tx_data);
      end
      phase    <= phase + 2'h1;
      tx_ready <= !stall || (phase == 2'h3);
    end
  end
endmodule

// File: tb/tsf_formatter_tb_top.sv
// Self-checking testbench of the telemetry stream formatter.
`timescale 1ns/10ps
module tsf_formatter_tb_top
  import tsf_pkg::*;
;
  localparam int PER = 1000;     // Shortened record period in cycles.
  logic         ref_clk = 1'b0;  // System clock, 200 MHz.
  logic         rst_n = 1'b0;    // Reset, active low.
  tsf_apb_req_s req = '0;        // Bus request.
  tsf_apb_rsp_s rsp;             // Bus answer.
  tsf_quant_s   quant;           // Live quantities.
  logic         motor_running = 1'b0;
  logic         stall = 1'b0;    // Makes the host slow.
  logic         tx_valid;
  logic         tx_ready;
  logic [7:0]   tx_data;
  logic [3:0]   sel [4];         // Selects as the bench wrote them.
  int           fail_count = 0;
  int           checks_done = 0;
  always #2.5 ref_clk = ~ref_clk;
  tsf_formatter #(.PERIOD_CYC(PER)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .quant(quant), .motor_running(motor_running), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  tsf_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_data(tx_data),
    .stall(stall), .tx_ready(tx_ready));
  // ---------------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------------
  // Value of quantity i: signs, sizes and the largest positive number vary.
  function automatic logic [31:0] qv(input int i);
    if (i == 10) return 32'h7FFF_FFFF;
    return (i % 3 == 0) ? -(i * 12345 + 7) : i * 98765;
  endfunction
  // Expected record text for the current selects.
  function automatic string rec();
    string s;
    s = "01";
    for (int k = 0; k < 4; k++) s = {s, ",", $sformatf("%0d", (sel[k] == 0 || sel[k] > 11) ? 0 : $signed(qv(sel[k] - 1)))};
    return {s, "\015\012"};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // One bus transfer: setup, then access until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp, "read data");
    chk({31'h0, er}, {31'h0, experr}, "slave error");
  endtask
  // Waits for a whole record and compares it byte by byte.
  task automatic get_rec(input string e);
    int n;
    n = 0;
    while (host.rx_q.size() < e.len() && n < 3 * PER) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3 * PER) begin
      fail_count++;
      results();
    end
    for (int i = 0; i < e.len(); i++) chk(32'(host.rx_q[i]), 32'(e[i]), "record byte");
    host.rx_q.delete();
  endtask
  // Checks that nothing at all is sent over the given span.
  task automatic quiet(input int cycles);
    host.rx_q.delete();
    repeat (cycles) @(posedge ref_clk);
    chk(32'(host.rx_q.size()), 32'h0, "unexpected bytes");
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  // Reset mode, fixed period, refused write and an unmapped address.
  task automatic t_regs();
    rd_chk(OFF_MODE, 32'h0, 1'b0);
    rd_chk(OFF_PERIOD, 32'h64, 1'b0);
    wr(OFF_PERIOD, 32'h7);
    rd_chk(OFF_PERIOD, 32'h64, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
  endtask
  // Every source code in four records, the second under a slow host; codes above eleven print zero.
  task automatic t_codes();
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 4; k++) begin
        sel[k] = 4'(4 * g + k);
        wr(OFF_CHAN0 + 8'(4 * k), {28'h0, sel[k]});
        rd_chk(OFF_CHAN0 + 8'(4 * k), {28'h0, sel[k]}, 1'b0);
      end
      stall <= (g == 1);
      if (g == 0) wr(OFF_MODE, 32'h1);
      get_rec(rec());
    end
    stall <= 1'b0;
    wr(OFF_MODE, 32'h0);
    quiet(2 * PER + 500);
  endtask
  // Records only while the motor turns.
  task automatic t_moving();
    wr(OFF_MODE, 32'h2);
    quiet(2 * PER + 500);
    motor_running <= 1'b1;
    get_rec(rec());
    // Status after five records: idle, motor running, count of five.
    rd_chk(OFF_STATUS, 32'h0000_0502, 1'b0);
    motor_running <= 1'b0;
    quiet(2 * PER + 500);
  endtask
  // A reset in mid-run returns the mode to disabled.
  task automatic t_reset();
    wr(OFF_MODE, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(OFF_MODE, 32'h0, 1'b0);
    quiet(PER + 500);
  endtask
  // Main sequence.
  initial begin
    for (int i = 0; i < NUM_SRC; i++) quant.val[i] = qv(i);
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_codes();
    t_moving();
    t_reset();
    results();
  end
endmodule
